// ### hw/drs_consts.vh
// Constants for the disk result status flag block.
`ifndef DRS_CONSTS_VH
`define DRS_CONSTS_VH
// First status byte field positions.
`define DRS_S0_CODE_HI     7
`define DRS_S0_CODE_LO     6
`define DRS_S0_POS_DONE    5
`define DRS_S0_HOME_FAULT  4
`define DRS_S0_NOT_OK      3
`define DRS_S0_HEAD        2
`define DRS_S0_UNIT_HI     1
`define DRS_S0_UNIT_LO     0
// Second status byte field positions.
`define DRS_S1_CYL_OVF     7
`define DRS_S1_UNUSED_HI   6
`define DRS_S1_CRC         5
`define DRS_S1_LATE        4
`define DRS_S1_UNUSED_LO   3
`define DRS_S1_SECT_MISS   2
`define DRS_S1_WR_LOCK     1
`define DRS_S1_ID_SYNC     0
// Completion codes.
`define DRS_CODE_NORMAL    2'h0
`define DRS_CODE_ABORTED   2'h1
`define DRS_CODE_INVALID   2'h2
// Step pulses allowed before a homing fault.
`define DRS_HOME_STEPS     8'hFF
// Reset values.
`define DRS_BYTE_RESET     8'h00
`define DRS_STEP_RESET     8'h00
// Index rises counted for the missing ID mark check.
`define DRS_INDEX_ARM      2'h1
`define DRS_INDEX_LIMIT    2'h2
// Result byte selectors.
`define DRS_SEL_FIRST      1'b0
`define DRS_SEL_SECOND     1'b1
`endif

// ### hw/drs_status.v
// Result status byte generator for a floppy disk formatter/controller.
`timescale 1ns/1ps
`include "drs_consts.vh"

// Behaviour notes for users of this block.
// Status bytes follow the working state through one register stage, so an
// event pulse sampled at one edge shows on the byte ports one edge later.
// Drive pins (track zero, write protect, index) cross into this clock
// domain through two flip-flops and therefore show two edges later still.
// Every error flag is sticky until the next command start; an event that
// lands in the start cycle itself wins, so no report is ever lost.
// The completion code, seek flag and homing fault also return to their
// quiet values at a command start, so each result reflects one command.
// Head side and drive number are only refreshed when an interrupt rises.
// The host handshake is reduced to ready and direction; byte order and the
// length of the result phase are owned by the command sequencer.
// Only the data-sync-lost bit of the third byte is kept here; the rest of
// that byte belongs to another block.

// What this block does
// - Top two bits of first byte give completion: normal, aborted, invalid.
// - Positioning-done flag set when a seek command finishes.
// - Homing fault set if track zero absent after 255 recalibrate steps.
// - Drive-not-ok flag always reads zero; drive presumed ready.
// - Head side captured into first byte when the interrupt is raised.
// - Two-bit drive number captured into first byte at interrupt.
// - Cylinder-overflow flag set on access beyond last sector of cylinder.
// - Two unused bits of second byte always read zero.
// - CRC-fault flag set on ID field or data field CRC mismatch.
// - Service-late flag set when host misses a data transfer deadline.
// - Sector-missing set when read, write deleted, scan or read ID fails.
// - Sector-missing also set when read track misses its starting sector.
// - Write-locked set on write protect during write or format commands.
// - ID-sync-lost set when no ID mark found after two index holes.
// - Missing data mark sets ID-sync-lost and data-sync-lost together.
// - Bytes leave via data register when ready and direction show output.
module drs_status (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       cmd_start,
  input  wire       cmd_done,
  input  wire       cmd_aborted,
  input  wire       cmd_invalid,
  input  wire       seek_done,
  input  wire       recal_active,
  input  wire       step_pulse,
  input  wire       track_zero,
  input  wire       head_sel,
  input  wire [1:0] unit_sel,
  input  wire       irq_raise,
  input  wire       cyl_overflow_ev,
  input  wire       id_crc_err_ev,
  input  wire       data_crc_err_ev,
  input  wire       late_service_ev,
  input  wire       sector_miss_ev,
  input  wire       read_id_fail_ev,
  input  wire       track_start_miss_ev,
  input  wire       write_cmd_active,
  input  wire       write_protect,
  input  wire       index_pulse,
  input  wire       id_mark_seen,
  input  wire       data_mark_miss_ev,
  input  wire       result_phase,
  input  wire       result_sel,
  input  wire       host_rd,
  output reg  [7:0] result_status_first,
  output reg  [7:0] result_status_second,
  output reg        data_sync_lost_flag,
  output reg  [7:0] data_out,
  output reg        host_xfer_ready,
  output reg        xfer_direction
);

  // Pin-side drive inputs pass two flip-flops before use.
  wire [2:0] pin_raw;
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  wire      tz_s;
  wire      wp_s;
  wire      idx_s;
  reg       idx_prev_reg;
  wire      idx_rise;
  genvar    g;

  // Combined event terms that feed the sticky flags.
  wire      crc_event;
  wire      miss_event;
  wire      lock_event;
  wire      id_mark_timeout;

  // Working state.
  reg [1:0] completion_code_reg;
  reg       positioning_done_reg;
  reg       homing_fault_reg;
  reg       head_side_reg;
  reg [1:0] drive_num_reg;
  reg       cyl_ovf_reg;
  reg       crc_fault_reg;
  reg       late_reg;
  reg       sector_missing_reg;
  reg       write_locked_reg;
  reg       id_sync_lost_reg;
  reg       data_sync_reg;
  reg [7:0] step_cnt_reg;
  reg [1:0] index_cnt_reg;
  reg       id_found_reg;
  reg [7:0] first_next;
  reg [7:0] second_next;

  assign pin_raw  = {index_pulse, write_protect, track_zero};
  assign tz_s     = pin_sync_reg[0];
  assign wp_s     = pin_sync_reg[1];
  assign idx_s    = pin_sync_reg[2];
  assign idx_rise = idx_s & ~idx_prev_reg;

  // Event terms; the missing ID mark fires on the second index rise.
  assign crc_event       = id_crc_err_ev | data_crc_err_ev;
  assign miss_event      = sector_miss_ev | read_id_fail_ev
                           | track_start_miss_ev;
  assign lock_event      = write_cmd_active & wp_s;
  assign id_mark_timeout = idx_rise && !id_found_reg && !id_mark_seen
                           && index_cnt_reg == `DRS_INDEX_ARM;

  // Two-stage synchroniser, one lane per drive pin; only stage two is read.
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin_sync
      always @(posedge mclk) begin
        if (!rst_n) begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  // Previous index level for edge detection; it resets to the idle low
  // level of the pin so that no false edge follows reset.
  always @(posedge mclk) begin
    if (!rst_n) begin
      idx_prev_reg <= 1'b0;
    end else begin
      idx_prev_reg <= idx_s;
    end
  end

  // Completion code; a code reported in the start cycle overrides the clear.
  always @(posedge mclk) begin
    if (!rst_n) begin
      completion_code_reg <= `DRS_CODE_NORMAL;
    end else if (cmd_invalid) begin
      completion_code_reg <= `DRS_CODE_INVALID;
    end else if (cmd_aborted) begin
      completion_code_reg <= `DRS_CODE_ABORTED;
    end else if (cmd_done || cmd_start) begin
      completion_code_reg <= `DRS_CODE_NORMAL;
    end
  end

  // Seek end flag; a seek finishing in the start cycle keeps the flag.
  always @(posedge mclk) begin
    if (!rst_n) begin
      positioning_done_reg <= 1'b0;
    end else if (seek_done) begin
      positioning_done_reg <= 1'b1;
    end else if (cmd_start) begin
      positioning_done_reg <= 1'b0;
    end
  end

  // Head side and drive number are frozen when the interrupt is raised.
  always @(posedge mclk) begin
    if (!rst_n) begin
      head_side_reg <= 1'b0;
      drive_num_reg <= 2'h0;
    end else if (irq_raise) begin
      head_side_reg <= head_sel;
      drive_num_reg <= unit_sel;
    end
  end

  // Recalibrate step counter; fault once 255 steps pass without track 0.
  // The count saturates at its limit so a long recalibrate cannot wrap and
  // hide the fault; track zero or leaving recalibrate restarts it.
  always @(posedge mclk) begin
    if (!rst_n) begin
      step_cnt_reg     <= `DRS_STEP_RESET;
      homing_fault_reg <= 1'b0;
    end else begin
      if (cmd_start) begin
        step_cnt_reg     <= `DRS_STEP_RESET;
        homing_fault_reg <= 1'b0;
      end
      if (!recal_active || tz_s) begin
        step_cnt_reg <= `DRS_STEP_RESET;
      end else if (step_pulse && step_cnt_reg != `DRS_HOME_STEPS) begin
        step_cnt_reg <= step_cnt_reg + 8'h01;
      end
      if (recal_active && !tz_s && step_cnt_reg == `DRS_HOME_STEPS) begin
        homing_fault_reg <= 1'b1;
      end
    end
  end

  // Index counting for the missing ID address mark check.
  always @(posedge mclk) begin
    if (!rst_n || cmd_start) begin
      index_cnt_reg <= 2'h0;
      id_found_reg  <= 1'b0;
    end else begin
      if (id_mark_seen) begin
        id_found_reg <= 1'b1;
      end
      if (idx_rise && index_cnt_reg != `DRS_INDEX_LIMIT) begin
        index_cnt_reg <= index_cnt_reg + `DRS_INDEX_ARM;
      end
    end
  end

  // End-of-cylinder flag; a set in the start cycle wins over the clear.
  always @(posedge mclk) begin
    if (!rst_n) begin
      cyl_ovf_reg <= 1'b0;
    end else if (cyl_overflow_ev) begin
      cyl_ovf_reg <= 1'b1;
    end else if (cmd_start) begin
      cyl_ovf_reg <= 1'b0;
    end
  end

  // CRC fault flag for either the ID field or the data field.
  always @(posedge mclk) begin
    if (!rst_n) begin
      crc_fault_reg <= 1'b0;
    end else if (crc_event) begin
      crc_fault_reg <= 1'b1;
    end else if (cmd_start) begin
      crc_fault_reg <= 1'b0;
    end
  end

  // Service-late flag for a host that missed a transfer deadline.
  always @(posedge mclk) begin
    if (!rst_n) begin
      late_reg <= 1'b0;
    end else if (late_service_ev) begin
      late_reg <= 1'b1;
    end else if (cmd_start) begin
      late_reg <= 1'b0;
    end
  end

  // Sector-missing flag, shared by all commands that search for a sector.
  always @(posedge mclk) begin
    if (!rst_n) begin
      sector_missing_reg <= 1'b0;
    end else if (miss_event) begin
      sector_missing_reg <= 1'b1;
    end else if (cmd_start) begin
      sector_missing_reg <= 1'b0;
    end
  end

  // Write-locked flag from the synchronised write protect pin.
  always @(posedge mclk) begin
    if (!rst_n) begin
      write_locked_reg <= 1'b0;
    end else if (lock_event) begin
      write_locked_reg <= 1'b1;
    end else if (cmd_start) begin
      write_locked_reg <= 1'b0;
    end
  end

  // ID-sync-lost flag from the index timeout or a missing data mark.
  always @(posedge mclk) begin
    if (!rst_n) begin
      id_sync_lost_reg <= 1'b0;
    end else if (id_mark_timeout || data_mark_miss_ev) begin
      id_sync_lost_reg <= 1'b1;
    end else if (cmd_start) begin
      id_sync_lost_reg <= 1'b0;
    end
  end

  // Data-sync-lost flag of the third byte, set with the one above.
  always @(posedge mclk) begin
    if (!rst_n) begin
      data_sync_reg <= 1'b0;
    end else if (data_mark_miss_ev) begin
      data_sync_reg <= 1'b1;
    end else if (cmd_start) begin
      data_sync_reg <= 1'b0;
    end
  end

  // Assemble both status bytes from the working state.
  // Fixed bits are written as constants so they can never pick up state.
  always @* begin
    first_next = `DRS_BYTE_RESET;
    first_next[`DRS_S0_CODE_HI]    = completion_code_reg[1];
    first_next[`DRS_S0_CODE_LO]    = completion_code_reg[0];
    first_next[`DRS_S0_POS_DONE]   = positioning_done_reg;
    first_next[`DRS_S0_HOME_FAULT] = homing_fault_reg;
    first_next[`DRS_S0_NOT_OK]     = 1'b0;
    first_next[`DRS_S0_HEAD]       = head_side_reg;
    first_next[`DRS_S0_UNIT_HI]    = drive_num_reg[1];
    first_next[`DRS_S0_UNIT_LO]    = drive_num_reg[0];
    second_next = `DRS_BYTE_RESET;
    second_next[`DRS_S1_CYL_OVF]   = cyl_ovf_reg;
    second_next[`DRS_S1_UNUSED_HI] = 1'b0;
    second_next[`DRS_S1_CRC]       = crc_fault_reg;
    second_next[`DRS_S1_LATE]      = late_reg;
    second_next[`DRS_S1_UNUSED_LO] = 1'b0;
    second_next[`DRS_S1_SECT_MISS] = sector_missing_reg;
    second_next[`DRS_S1_WR_LOCK]   = write_locked_reg;
    second_next[`DRS_S1_ID_SYNC]   = id_sync_lost_reg;
  end

  // Registered outputs and the result-phase data register handshake.
  // The data register mirrors the selected byte one edge after the working
  // state, the same latency as the byte ports themselves.
  always @(posedge mclk) begin
    if (!rst_n) begin
      result_status_first  <= `DRS_BYTE_RESET;
      result_status_second <= `DRS_BYTE_RESET;
      data_sync_lost_flag  <= 1'b0;
      data_out             <= `DRS_BYTE_RESET;
      host_xfer_ready      <= 1'b0;
      xfer_direction       <= 1'b0;
    end else begin
      result_status_first  <= first_next;
      result_status_second <= second_next;
      data_sync_lost_flag  <= data_sync_reg;
      xfer_direction       <= result_phase;
      // Ready drops for one cycle after each read so the host re-polls.
      host_xfer_ready      <= result_phase & ~host_rd;
      data_out <= (result_sel == `DRS_SEL_SECOND) ? second_next
                                                  : first_next;
    end
  end

endmodule // drs_status

// ### sim/drs_status_properties.sv
// Concurrent checks on the result status byte ports.
`timescale 1ns/1ps
module drs_status_properties (
  input wire       mclk,
  input wire       rst_n,
  input wire       cmd_start,
  input wire       cmd_invalid,
  input wire       seek_done,
  input wire       id_crc_err_ev,
  input wire       data_mark_miss_ev,
  input wire       result_phase,
  input wire       host_rd,
  input wire [7:0] result_status_first,
  input wire [7:0] result_status_second,
  input wire       data_sync_lost_flag,
  input wire       host_xfer_ready,
  input wire       xfer_direction
);
  // Every check runs on the controller clock and idles in reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Event inputs reach the bytes two edges after they are sampled.
  code_invalid_a: assert property (cmd_invalid |-> ##2
    result_status_first[7:6] == 2'h2) else $error("invalid code lost");
  seek_flag_a: assert property (seek_done |-> ##2
    result_status_first[5]) else $error("seek flag lost");
  not_ok_zero_a: assert property (!result_status_first[3])
    else $error("drive flag set");
  crc_flag_a: assert property (id_crc_err_ev |-> ##2
    result_status_second[5]) else $error("crc flag lost");
  spare_bits_a: assert property (!result_status_second[6] &&
    !result_status_second[3]) else $error("spare bit set");
  mark_miss_a: assert property (data_mark_miss_ev |-> ##2
    result_status_second[0] && data_sync_lost_flag) else $error("mark");
  flag_clear_a: assert property (cmd_start && !data_mark_miss_ev
    ##1 !data_mark_miss_ev |-> ##1 !data_sync_lost_flag)
    else $error("flag not cleared");
  ready_follow_a: assert property (result_phase && !host_rd |=>
    host_xfer_ready && xfer_direction) else $error("ready missing");
  ready_dir_a: assert property (host_xfer_ready |-> xfer_direction)
    else $error("wrong direction");
  ready_drop_a: assert property (host_rd |=> !host_xfer_ready)
    else $error("ready held after read");
endmodule // drs_status_properties

// ### sim/drs_host_model.sv
// Host model that pulls result bytes out of the data register.
`timescale 1ns/1ps
module drs_host_model (
  input  wire       mclk,
  input  wire       host_xfer_ready,
  input  wire       xfer_direction,
  input  wire [7:0] data_out,
  output reg        result_sel,
  output reg        host_rd
);
  // Host starts idle, first byte selected.
  initial begin
    result_sel = 1'b0;
    host_rd = 1'b0;
  end
  // Waits for ready toward the host, selects a byte, then takes it.
  task read_byte(input reg sel, output reg [7:0] b, output reg ok);
    integer i;
    begin
      ok = 1'b0;
      for (i = 0; i < 50 && !ok; i = i + 1) begin
        @(posedge mclk);
        ok = host_xfer_ready && xfer_direction;
      end
      result_sel <= sel;
      repeat (2) @(posedge mclk);
      b = data_out;
      host_rd <= 1'b1;
      @(posedge mclk);
      host_rd <= 1'b0;
    end
  endtask
endmodule // drs_host_model

// ### sim/tb.sv
// Self-checking bench for the result status byte generator.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected %0t got %h exp %h", $time, a, e); end end
module tb;
  reg        mclk = 1'b0;
  reg        rst_n = 1'b0;
  reg [15:0] ev = 16'h0000;
  reg        recal_active = 1'b0, track_zero = 1'b0, head_sel = 1'b0;
  reg [1:0]  unit_sel = 2'h0;
  reg        write_cmd_active = 1'b0, write_protect = 1'b0;
  reg        index_pulse = 1'b0, result_phase = 1'b0;
  wire [7:0] result_status_first, result_status_second, data_out;
  wire       data_sync_lost_flag, host_xfer_ready, xfer_direction;
  wire       result_sel, host_rd;
  integer    n_errors = 0, num_checks = 0, i, k;
  reg [7:0]  rb;
  reg        ok;
  // Free running 125 MHz clock.
  always #4 mclk = ~mclk;
  drs_status drs_status_inst (
    .mclk, .rst_n, .cmd_start(ev[0]), .cmd_done(ev[1]),
    .cmd_aborted(ev[2]), .cmd_invalid(ev[3]), .seek_done(ev[4]),
    .recal_active, .step_pulse(ev[5]), .track_zero, .head_sel,
    .unit_sel, .irq_raise(ev[6]), .cyl_overflow_ev(ev[7]),
    .id_crc_err_ev(ev[8]), .data_crc_err_ev(ev[9]),
    .late_service_ev(ev[10]), .sector_miss_ev(ev[11]),
    .read_id_fail_ev(ev[12]), .track_start_miss_ev(ev[13]),
    .write_cmd_active, .write_protect, .index_pulse,
    .id_mark_seen(ev[14]), .data_mark_miss_ev(ev[15]),
    .result_phase, .result_sel, .host_rd, .result_status_first,
    .result_status_second, .data_sync_lost_flag, .data_out,
    .host_xfer_ready, .xfer_direction);
  drs_host_model drs_host_model_inst (
    .mclk, .host_xfer_ready, .xfer_direction, .data_out,
    .result_sel, .host_rd);
  // Prints the verdict and ends the run.
  task final_report;
    begin
      if (n_errors == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Raises one event input for a single clock.
  task pulse(input integer n);
    begin
      @(posedge mclk);
      ev[n] <= 1'b1;
      @(posedge mclk);
      ev[n] <= 1'b0;
    end
  endtask
  // Gives pin synchronisers and output stages time to land.
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  // Reads one result byte; a host that never sees ready is a failure.
  task rd(input reg sel);
    begin
      drs_host_model_inst.read_byte(sel, rb, ok);
      if (!ok) begin
        n_errors++;
        final_report;
      end
    end
  endtask
  // One index hole passing under the head.
  task idx;
    begin
      index_pulse <= 1'b1;
      repeat (3) @(posedge mclk);
      index_pulse <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // Second byte expected after a single medium error event.
  function [7:0] exp2(input integer n);
    case (n)
      7: exp2 = 8'h80;
      8, 9: exp2 = 8'h20;
      10: exp2 = 8'h10;
      15: exp2 = 8'h01;
      default: exp2 = 8'h04;
    endcase
  endfunction
  // Main sequence of commands and result reads.
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    settle;
    `CHK(result_status_first, 8'h00)
    `CHK(result_status_second, 8'h00)
    for (k = 1; k < 4; k++) begin
      pulse(0);
      pulse(k);
      settle;
      `CHK(result_status_first[7:6], k[1:0] - 2'h1)
    end
    pulse(4);
    settle;
    `CHK(result_status_first[5], 1'b1)
    head_sel <= 1'b1;
    unit_sel <= 2'h2;
    pulse(6);
    head_sel <= 1'b0;
    unit_sel <= 2'h1;
    settle;
    `CHK(result_status_first[2:0], 3'h6)
    pulse(0);
    recal_active <= 1'b1;
    for (i = 0; i < 254; i++) pulse(5);
    settle;
    `CHK(result_status_first[4], 1'b0)
    pulse(5);
    settle;
    `CHK(result_status_first[4], 1'b1)
    recal_active <= 1'b0;
    result_phase <= 1'b1;
    for (k = 7; k < 16; k++) if (k != 14) begin
      pulse(0);
      pulse(k);
      settle;
      rd(1'b1);
      `CHK(rb, exp2(k))
    end
    `CHK(data_sync_lost_flag, 1'b1)
    rd(1'b0);
    `CHK(rb, 8'h06)
    pulse(0);
    write_cmd_active <= 1'b1;
    write_protect <= 1'b1;
    settle;
    rd(1'b1);
    `CHK(rb, 8'h02)
    write_cmd_active <= 1'b0;
    pulse(0);
    pulse(14);
    idx;
    idx;
    settle;
    `CHK(result_status_second[0], 1'b0)
    pulse(0);
    idx;
    idx;
    settle;
    `CHK(result_status_second[0], 1'b1)
    final_report;
  end
endmodule // tb
bind drs_status drs_status_properties drs_status_properties_inst (
  .mclk, .rst_n, .cmd_start, .cmd_invalid, .seek_done, .id_crc_err_ev,
  .data_mark_miss_ev, .result_phase, .host_rd, .result_status_first,
  .result_status_second, .data_sync_lost_flag, .host_xfer_ready,
  .xfer_direction);
